// ### bcod_pkg.sv
// Constants, types and register map of the branch/call/operand decoder.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
package bcod_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses, one aligned 32-bit word each; OFS_PTR_BASE is the word index of four pointers)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_PC = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_ACCUM = 8'h0C;
   localparam logic [7:0] OFS_BANK = 8'h10;
   localparam logic [7:0] OFS_SHADOW = 8'h14;
   localparam logic [7:0] OFS_STACK = 8'h18;
   localparam logic [7:0] OFS_TPTR = 8'h1C;
   localparam logic [7:0] OFS_TLAT = 8'h20;
   localparam logic [7:0] OFS_PMRD = 8'h24;
   localparam logic [7:0] OFS_PMWR = 8'h28;
   localparam logic [5:0] OFS_PTR_BASE = 6'h0B;
   localparam logic [7:0] OFS_DECODE = 8'h3C;
   localparam logic [7:0] OFS_MOVE = 8'h40;

   // -----------------------------------------------------------------
   // Reset values, steps, access bank and index pointer
   // -----------------------------------------------------------------
   localparam logic [20:0] RST_PC = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [20:0] TPTR_STEP = 21'h000001;
   localparam logic [4:0] RST_SP = 5'h00;
   localparam logic [4:0] SP_STEP = 5'h01;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [1:0] INDEX_PTR = 2'h2;

   // -----------------------------------------------------------------
   // Quarter-cycle timing
   // -----------------------------------------------------------------
   localparam logic [1:0] Q_READ = 2'h1;
   localparam logic [1:0] Q_PUSH = 2'h2;
   localparam logic [1:0] Q_WRITE = 2'h3;
   localparam logic [1:0] Q_LAST = 2'h3;

   // -----------------------------------------------------------------
   // Opcode patterns
   // -----------------------------------------------------------------
   localparam logic [7:0] OPC_BRZ = 8'hE0;
   localparam logic [6:0] OPC_CALL = 7'h76;
   localparam logic [9:0] OPC_LFSR = 10'h3B8;
   localparam logic [8:0] OPC_MOVSS = 9'h1D7;
   localparam logic [3:0] OPC_MOVFF = 4'hC;
   localparam logic [3:0] OPC_SECOND = 4'hF;
   localparam logic [12:0] OPC_TBL = 13'h0001;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT2, ST_EXEC} bcod_state_t;
   typedef enum logic [2:0] {K_GEN, K_BRZ, K_CALL, K_LFSR, K_MOVFF,
      K_MOVSS, K_TBLRD, K_TBLWT} bcod_kind_t;
   typedef enum logic [1:0] {TM_KEEP, TM_POSTINC, TM_POSTDEC,
      TM_PREINC} bcod_tmode_t;

   typedef struct packed {
      logic negative;
      logic overflow_flag;
      logic zero;
      logic nibble_carry_flag;
      logic carry;
   } bcod_flags_t;

   typedef struct packed {
      logic [7:0] accumulator_shadow;
      bcod_flags_t flags_shadow;
      logic [3:0] bank_selector_shadow;
   } bcod_shadow_t;

   typedef struct packed {
      logic dest_file;
      logic ram_banked;
      logic [1:0] ptr_sel;
      logic [11:0] file_addr;
   } bcod_decode_t;

endpackage

// ### bcod_qseq.sv
// Quarter-cycle sequencer: four clocks per instruction cycle.
// Assumes start_in is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module bcod_qseq (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Control
   input wire logic start_in,
   input wire logic two_cyc_in,
   // Position
   output logic [1:0] quarter_out,
   output logic cycle_out,
   output logic done_out
);

   logic run;
   logic two;
   logic [1:0] q;
   logic cyc;
   logic next_run;
   logic next_two;
   logic [1:0] next_q;
   logic next_cyc;

   // -----------------------------------------------------------------
   // Sequencing
   // -----------------------------------------------------------------
   assign done_out = run && (q == bcod_pkg::Q_LAST) && (cyc == two);
   assign quarter_out = q;
   assign cycle_out = cyc;

   // Next position; done ends the run on the last quarter
   always_comb
   begin
      next_run = run;
      next_two = two;
      next_q = q;
      next_cyc = cyc;
      if (start_in)
      begin
         next_run = 1'b1;
         next_two = two_cyc_in;
         next_q = 2'h0;
         next_cyc = 1'b0;
      end
      else if (run)
      begin
         next_q = q + 2'h1;
         if (q == bcod_pkg::Q_LAST)
            next_cyc = ~cyc;
         if (done_out)
            next_run = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         run <= 1'b0;
         two <= 1'b0;
         q <= 2'h0;
         cyc <= 1'b0;
      end
      else
      begin
         run <= next_run;
         two <= next_two;
         q <= next_q;
         cyc <= next_cyc;
      end
   end

endmodule // bcod_qseq

// ### bcod_core.sv
// Branch/call execute unit with operand decode, Avalon-MM slave.
// Assumes software feeds instruction words and a waitrequest master.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bcod_core (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Core status
   output logic busy_out,
   output logic [20:0] pc_out
);

   bcod_pkg::bcod_state_t state, next_state;
   bcod_pkg::bcod_kind_t kind, next_kind, wkind;
   logic [15:0] w1, next_w1, w2, next_w2;
   logic taken, next_taken;
   logic [20:0] pc, next_pc;
   bcod_pkg::bcod_flags_t flags, next_flags;
   logic [7:0] accum, next_accum;
   logic [3:0] bank, next_bank;
   bcod_pkg::bcod_shadow_t shadow, next_shadow;
   logic [20:0] stack_top, next_stack_top;
   logic [4:0] sp, next_sp;
   logic [20:0] tptr, next_tptr, taddr;
   logic [7:0] tlat, next_tlat, pmrd, next_pmrd;
   logic [28:0] pmwr, next_pmwr;
   logic [11:0] ptr_reg [4];
   logic [11:0] next_ptr_reg [4];
   bcod_pkg::bcod_decode_t dec, next_dec;
   logic [11:0] src, next_src, dst, next_dst;
   logic rd_ack, next_rd_ack;
   logic [31:0] rdata, next_rdata;
   logic wr_ok, issue, start, two_cyc, done, cyc;
   logic [1:0] q;
   logic [15:0] wd;
   logic [20:0] brz_target, call_target;

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   // Writes stall while executing so software never races the core
   assign wr_ok = avs_write_in && (state != bcod_pkg::ST_EXEC);
   assign avs_waitrequest_out = avs_read_in ? !rd_ack :
      (avs_write_in && !wr_ok);
   assign avs_readdata_out = rdata;
   assign busy_out = (state == bcod_pkg::ST_EXEC);
   assign pc_out = pc;
   assign wd = avs_writedata_in[15:0];
   assign issue = wr_ok && (avs_address_in == bcod_pkg::OFS_INSTR);

   // Read data registered one cycle, unmapped reads return zero
   always_comb
   begin
      next_rd_ack = avs_read_in && !rd_ack;
      next_rdata = rdata;
      if (avs_read_in && !rd_ack)
      begin
         next_rdata = 32'h00000000;
         case (avs_address_in)
            bcod_pkg::OFS_INSTR:
               next_rdata = {30'h0, state == bcod_pkg::ST_WAIT2, busy_out};
            bcod_pkg::OFS_PC: next_rdata = {11'h0, pc};
            bcod_pkg::OFS_FLAGS: next_rdata = {27'h0, flags};
            bcod_pkg::OFS_ACCUM: next_rdata = {24'h0, accum};
            bcod_pkg::OFS_BANK: next_rdata = {28'h0, bank};
            bcod_pkg::OFS_SHADOW: next_rdata = {15'h0, shadow};
            bcod_pkg::OFS_STACK: next_rdata = {6'h0, sp, stack_top};
            bcod_pkg::OFS_TPTR: next_rdata = {11'h0, tptr};
            bcod_pkg::OFS_TLAT: next_rdata = {24'h0, tlat};
            bcod_pkg::OFS_PMRD: next_rdata = {24'h0, pmrd};
            bcod_pkg::OFS_PMWR: next_rdata = {3'h0, pmwr};
            bcod_pkg::OFS_DECODE: next_rdata = {16'h0, dec};
            bcod_pkg::OFS_MOVE: next_rdata = {8'h0, src, dst};
            default:
               if (avs_address_in[7:2] >= bcod_pkg::OFS_PTR_BASE &&
                  avs_address_in[7:2] < bcod_pkg::OFS_PTR_BASE + 6'h4)
                  next_rdata = {20'h0, ptr_reg[avs_address_in[3:2] +
                     2'h1]};
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         rd_ack <= 1'b0;
         rdata <= 32'h00000000;
      end
      else
      begin
         rd_ack <= next_rd_ack;
         rdata <= next_rdata;
      end
   end

   // -----------------------------------------------------------------
   // Word classification
   // -----------------------------------------------------------------
   always_comb
   begin
      wkind = bcod_pkg::K_GEN;
      if (wd[15:8] == bcod_pkg::OPC_BRZ)
         wkind = bcod_pkg::K_BRZ;
      else if (wd[15:9] == bcod_pkg::OPC_CALL)
         wkind = bcod_pkg::K_CALL;
      else if (wd[15:6] == bcod_pkg::OPC_LFSR)
         wkind = bcod_pkg::K_LFSR;
      else if (wd[15:7] == bcod_pkg::OPC_MOVSS)
         wkind = bcod_pkg::K_MOVSS;
      else if (wd[15:12] == bcod_pkg::OPC_MOVFF)
         wkind = bcod_pkg::K_MOVFF;
      else if (wd[15:3] == bcod_pkg::OPC_TBL)
         wkind = wd[2] ? bcod_pkg::K_TBLWT : bcod_pkg::K_TBLRD;
   end

   // Branch target from the already incremented counter
   assign brz_target = pc + bcod_pkg::PC_STEP +
      {{12{wd[7]}}, wd[7:0], 1'b0};
   assign call_target = {wd[11:0], w1[7:0], 1'b0};
   assign taddr = (w1[1:0] == 2'(bcod_pkg::TM_PREINC)) ?
      tptr + bcod_pkg::TPTR_STEP : tptr;

   bcod_qseq u_qseq (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .start_in(start),
      .two_cyc_in(two_cyc),
      .quarter_out(q),
      .cycle_out(cyc),
      .done_out(done)
   );

   // -----------------------------------------------------------------
   // Core state: issue, execute quarters, software writes
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_kind = kind;
      next_w1 = w1;
      next_w2 = w2;
      next_taken = taken;
      next_pc = pc;
      next_flags = flags;
      next_accum = accum;
      next_bank = bank;
      next_shadow = shadow;
      next_stack_top = stack_top;
      next_sp = sp;
      next_tptr = tptr;
      next_tlat = tlat;
      next_pmrd = pmrd;
      next_pmwr = pmwr;
      next_ptr_reg = ptr_reg;
      next_dec = dec;
      next_src = src;
      next_dst = dst;
      start = 1'b0;
      two_cyc = 1'b1;
      unique case (state)
         bcod_pkg::ST_IDLE:
            if (issue)
            begin
               next_kind = wkind;
               next_w1 = wd;
               // Operand fields of every first word
               next_dec.dest_file = wd[9];
               next_dec.ram_banked = wd[8];
               next_dec.ptr_sel = wd[1:0];
               next_dec.file_addr = wd[8] ? {bank, wd[7:0]} :
                  {bcod_pkg::ACCESS_BANK, wd[7:0]};
               if (wkind == bcod_pkg::K_CALL || wkind == bcod_pkg::K_LFSR
                  || wkind == bcod_pkg::K_MOVFF ||
                  wkind == bcod_pkg::K_MOVSS)
               begin
                  next_pc = pc + bcod_pkg::PC_STEP;
                  next_state = bcod_pkg::ST_WAIT2;
               end
               else
               begin
                  next_pc = pc + bcod_pkg::PC_STEP;
                  next_state = bcod_pkg::ST_EXEC;
                  next_taken = flags.zero;
                  start = 1'b1;
                  // Only a taken branch or a table op needs two cycles
                  two_cyc = (wkind == bcod_pkg::K_BRZ) ? flags.zero :
                     (wkind != bcod_pkg::K_GEN);
               end
            end
         bcod_pkg::ST_WAIT2:
            if (issue)
            begin
               // A second word without the 1111 prefix aborts the op
               if (wd[15:12] == bcod_pkg::OPC_SECOND)
               begin
                  next_w2 = wd;
                  next_pc = pc + bcod_pkg::PC_STEP;
                  next_state = bcod_pkg::ST_EXEC;
                  start = 1'b1;
                  two_cyc = 1'b1;
               end
               else
                  next_state = bcod_pkg::ST_IDLE;
            end
         bcod_pkg::ST_EXEC:
         begin
            if (done)
               next_state = bcod_pkg::ST_IDLE;
            if (!cyc && q == bcod_pkg::Q_PUSH && kind == bcod_pkg::K_CALL)
            begin
               next_stack_top = pc;
               next_sp = sp + bcod_pkg::SP_STEP;
               if (w1[8])
                  next_shadow = {accum, flags, bank};
            end
            if (!cyc && q == bcod_pkg::Q_WRITE)
               unique case (kind)
                  bcod_pkg::K_BRZ:
                     if (taken)
                        next_pc = pc + {{12{w1[7]}}, w1[7:0], 1'b0};
                  bcod_pkg::K_CALL:
                     next_pc = {w2[11:0], w1[7:0], 1'b0};
                  bcod_pkg::K_MOVFF:
                  begin
                     next_src = w1[11:0];
                     next_dst = w2[11:0];
                  end
                  bcod_pkg::K_MOVSS:
                  begin
                     next_src = ptr_reg[bcod_pkg::INDEX_PTR] +
                        {5'h00, w1[6:0]};
                     next_dst = ptr_reg[bcod_pkg::INDEX_PTR] +
                        {5'h00, w2[6:0]};
                  end
                  default:
                     next_pc = pc;
               endcase
            if (cyc && q == bcod_pkg::Q_WRITE)
               unique case (kind)
                  bcod_pkg::K_LFSR:
                     next_ptr_reg[w1[5:4]] = {w1[3:0], w2[7:0]};
                  bcod_pkg::K_TBLRD, bcod_pkg::K_TBLWT:
                  begin
                     // 21-bit pointer, 8-bit latch
                     if (kind == bcod_pkg::K_TBLRD)
                        next_tlat = pmrd;
                     else
                        next_pmwr = {taddr, tlat};
                     unique case (bcod_pkg::bcod_tmode_t'(w1[1:0]))
                        bcod_pkg::TM_KEEP: next_tptr = tptr;
                        bcod_pkg::TM_POSTDEC:
                           next_tptr = tptr - bcod_pkg::TPTR_STEP;
                        bcod_pkg::TM_POSTINC, bcod_pkg::TM_PREINC:
                           next_tptr = tptr + bcod_pkg::TPTR_STEP;
                     endcase
                  end
                  default:
                     next_tptr = tptr;
               endcase
         end
      endcase
      // Software writes; never during execution, so branch and call
      // cannot disturb the flags
      if (wr_ok)
         case (avs_address_in)
            bcod_pkg::OFS_PC: next_pc = avs_writedata_in[20:0];
            bcod_pkg::OFS_FLAGS:
               next_flags = avs_writedata_in[4:0];
            bcod_pkg::OFS_ACCUM: next_accum = avs_writedata_in[7:0];
            bcod_pkg::OFS_BANK: next_bank = avs_writedata_in[3:0];
            bcod_pkg::OFS_TPTR: next_tptr = avs_writedata_in[20:0];
            bcod_pkg::OFS_TLAT: next_tlat = avs_writedata_in[7:0];
            bcod_pkg::OFS_PMRD: next_pmrd = avs_writedata_in[7:0];
            default:
               if (avs_address_in[7:2] >= bcod_pkg::OFS_PTR_BASE &&
                  avs_address_in[7:2] < bcod_pkg::OFS_PTR_BASE + 6'h4)
                  next_ptr_reg[avs_address_in[3:2] + 2'h1] =
                     avs_writedata_in[11:0];
         endcase
   end

   // Core registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         state <= bcod_pkg::ST_IDLE;
         kind <= bcod_pkg::K_GEN;
         w1 <= 16'h0000;
         w2 <= 16'h0000;
         taken <= 1'b0;
         pc <= bcod_pkg::RST_PC;
         flags <= '0;
         accum <= 8'h00;
         bank <= 4'h0;
         shadow <= '0;
         stack_top <= 21'h000000;
         sp <= bcod_pkg::RST_SP;
         tptr <= 21'h000000;
         tlat <= 8'h00;
         pmrd <= 8'h00;
         pmwr <= 29'h00000000;
         ptr_reg <= '{default: 12'h000};
         dec <= '0;
         src <= 12'h000;
         dst <= 12'h000;
      end
      else
      begin
         state <= next_state;
         kind <= next_kind;
         w1 <= next_w1;
         w2 <= next_w2;
         taken <= next_taken;
         pc <= next_pc;
         flags <= next_flags;
         accum <= next_accum;
         bank <= next_bank;
         shadow <= next_shadow;
         stack_top <= next_stack_top;
         sp <= next_sp;
         tptr <= next_tptr;
         tlat <= next_tlat;
         pmrd <= next_pmrd;
         pmwr <= next_pmwr;
         ptr_reg <= next_ptr_reg;
         dec <= next_dec;
         src <= next_src;
         dst <= next_dst;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   logic go_brz, go_call;
   assign go_brz = start && wkind == bcod_pkg::K_BRZ &&
      state == bcod_pkg::ST_IDLE;
   assign go_call = start && state == bcod_pkg::ST_WAIT2 &&
      kind == bcod_pkg::K_CALL;

   sequence s_two_cycles;
      busy_out [*8] ##1 !busy_out;
   endsequence
   sequence s_one_cycle;
      busy_out [*4] ##1 !busy_out;
   endsequence

   AST_BRZ_TARGET: assert property (go_brz && flags.zero |-> ##5
      pc == $past(brz_target, 5)) else $error("bad branch target");
   AST_BRZ_TWO: assert property (go_brz && flags.zero |=>
      s_two_cycles) else $error("taken branch length");
   AST_BRZ_ONE: assert property (go_brz && !flags.zero |=>
      s_one_cycle ##0 pc == $past(pc, 5) + bcod_pkg::PC_STEP)
      else $error("untaken branch wrong");
   AST_CALL_PUSH: assert property (go_call |-> ##4
      stack_top == $past(pc, 4) + bcod_pkg::PC_STEP)
      else $error("call push address");
   AST_CALL_TARGET: assert property (go_call |-> ##5
      pc == $past(call_target, 5)) else $error("call target");
   AST_CALL_FAST: assert property (go_call && w1[8] |-> ##4
      shadow == {accum, flags, bank}) else $error("no shadow copy");
   AST_CALL_SLOW: assert property (go_call && !w1[8] |=>
      $stable(shadow) [*8]) else $error("shadow changed");
   AST_CALL_TWO: assert property (go_call |=> s_two_cycles)
      else $error("call length");
   AST_FLAGS_KEPT: assert property (busy_out &&
      (kind == bcod_pkg::K_BRZ || kind == bcod_pkg::K_CALL) |=>
      $stable(flags)) else $error("flags changed");

endmodule // bcod_core

// ### test_bcod_core.sv
// Self-checking bench for the branch/call/operand execute unit.
// Assumes bcod_pkg is compiled first; bench acts as Avalon-MM master.
`timescale 1ns/1ps
`define CHK(a, b) compares++; if ((a) !== (b)) begin failures++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end
module test_bcod_core;
   // Clock, reset and bus
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic busy_out;
   logic [20:0] pc_out;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   logic [31:0] rv;
   typedef struct {logic [15:0] w; logic [4:0] fl; logic [20:0] pc0;
      logic [20:0] pc1; int cyc;} bcod_row_t;
   bcod_row_t rows [5] = '{
      '{16'hE0FE, 5'h04, 21'h100, 21'h0FE, 8},
      '{16'hE07F, 5'h04, 21'h100, 21'h200, 8},
      '{16'hE080, 5'h04, 21'h1000, 21'hF02, 8},
      '{16'hE07F, 5'h1B, 21'h100, 21'h102, 4},
      '{16'hE1FE, 5'h04, 21'h100, 21'h102, 4}};
   logic [20:0] tmode_exp [4] = '{21'h100, 21'h101, 21'h0FF, 21'h101};
   // Byte address of the pointer that indexed moves use
   localparam logic [7:0] PTR2_ADDR =
      {bcod_pkg::OFS_PTR_BASE + 6'(bcod_pkg::INDEX_PTR), 2'b00};

   bcod_core u_bcod_core (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .busy_out(busy_out), .pc_out(pc_out));

   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   // Edge first, so a release never meets a new request in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= 1'b1;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      avs_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_read_in <= 1'b1;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      d = avs_readdata_out;
      avs_read_in <= 1'b0;
   endtask
   // Issue a word, then count the cycles the core reports busy
   task automatic run(input logic [15:0] w, output int c);
      wr(bcod_pkg::OFS_INSTR, {16'h0, w});
      c = 0;
      do begin @(posedge clk_in); c += busy_out === 1'b1; end
      while (busy_out === 1'b1 && c < 20);
   endtask
   task automatic end_sim();
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      `CHK(pc_out, 21'h0)
      // Branch rows: taken, extreme offsets, untaken, near opcode
      foreach (rows[i])
      begin
         wr(bcod_pkg::OFS_FLAGS, {27'h0, rows[i].fl});
         wr(bcod_pkg::OFS_PC, {11'h0, rows[i].pc0});
         run(rows[i].w, n);
         `CHK(n, rows[i].cyc)
         `CHK(pc_out, rows[i].pc1)
         rd(bcod_pkg::OFS_FLAGS, rv);
         `CHK(rv, {27'h0, rows[i].fl})
      end
      // Fast call saves shadows, pushes address plus four
      wr(bcod_pkg::OFS_FLAGS, 32'h1F);
      wr(bcod_pkg::OFS_ACCUM, 32'h5A);
      wr(bcod_pkg::OFS_BANK, 32'h3);
      wr(bcod_pkg::OFS_PC, 32'h200);
      wr(bcod_pkg::OFS_INSTR, 32'hED34);
      run(16'hF123, n);
      `CHK(n, 8)
      `CHK(pc_out, 21'h24668)
      rd(bcod_pkg::OFS_STACK, rv);
      `CHK(rv, 32'h200204)
      rd(bcod_pkg::OFS_SHADOW, rv);
      `CHK(rv, 32'hB5F3)
      rd(bcod_pkg::OFS_FLAGS, rv);
      `CHK(rv, 32'h1F)
      // Plain call: shadows must hold; shadow is read-only
      wr(bcod_pkg::OFS_ACCUM, 32'h11);
      wr(bcod_pkg::OFS_SHADOW, 32'hFFFF);
      wr(bcod_pkg::OFS_INSTR, 32'hEC00);
      run(16'hF000, n);
      `CHK(pc_out, 21'h0)
      rd(bcod_pkg::OFS_SHADOW, rv);
      `CHK(rv, 32'hB5F3)
      rd(bcod_pkg::OFS_STACK, rv);
      `CHK(rv, 32'h42466C)
      // Operand fields: banked/destination versus access bank
      run(16'h27AB, n);
      rd(bcod_pkg::OFS_DECODE, rv);
      `CHK(rv & 32'hCFFF, 32'hC3AB)
      run(16'h24AB, n);
      rd(bcod_pkg::OFS_DECODE, rv);
      `CHK(rv & 32'hCFFF, 32'h00AB)
      // Full-width move and indexed move
      wr(bcod_pkg::OFS_INSTR, 32'hC123);
      run(16'hF456, n);
      rd(bcod_pkg::OFS_MOVE, rv);
      `CHK(rv, 32'h123456)
      wr(PTR2_ADDR, 32'h100);
      wr(bcod_pkg::OFS_INSTR, 32'hEB85);
      run(16'hF003, n);
      rd(bcod_pkg::OFS_MOVE, rv);
      `CHK(rv, 32'h105103)
      // Pointer load: the 2-bit selector picks pointer 2 of four
      wr(bcod_pkg::OFS_INSTR, 32'hEE25);
      run(16'hF0AB, n);
      rd(PTR2_ADDR, rv);
      `CHK(rv, 32'h5AB)
      // Every table pointer mode on a read
      for (int m = 0; m < 4; m++)
      begin
         wr(bcod_pkg::OFS_TPTR, 32'h100);
         wr(bcod_pkg::OFS_PMRD, 32'h70 + m);
         run(16'h0008 + 16'(m), n);
         rd(bcod_pkg::OFS_TPTR, rv);
         `CHK(rv, {11'h0, tmode_exp[m]})
         rd(bcod_pkg::OFS_TLAT, rv);
         `CHK(rv, 32'h70 + m)
      end
      // Pre-increment write at the top of the 21-bit pointer wraps
      wr(bcod_pkg::OFS_TPTR, 32'h1FFFFF);
      wr(bcod_pkg::OFS_TLAT, 32'hC3);
      run(16'h000F, n);
      rd(bcod_pkg::OFS_PMWR, rv);
      `CHK(rv, 32'hC3)
      rd(8'hFC, rv);
      `CHK(rv, 32'h0)
      // Reset while idle after the last op clears counter and stack
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      `CHK(pc_out, 21'h0)
      `CHK(busy_out, 1'b0)
      rst_b_in <= 1'b1;
      rd(bcod_pkg::OFS_STACK, rv);
      `CHK(rv, 32'h0)
      end_sim();
   end
endmodule // test_bcod_core
